// ==== rtl/sw_regs.svh ====
// register offsets, region bounds, field positions and reset values of the switch register map
`ifndef SW_REGS_SVH
`define SW_REGS_SVH

`define SW_OFF_FAMILY 8'h00
`define SW_OFF_CHIP 8'h01
`define SW_GLOBAL_LO 8'h02
`define SW_GLOBAL_HI 8'h0B
`define SW_RSVD_GLOBAL 8'h0C
`define SW_USER_LO 8'h0D
`define SW_USER_HI 8'h0F
`define SW_PORT_LO 8'h10
`define SW_PORT_HI 8'h3F
`define SW_PCTL_LAST 4'hD
`define SW_PSTAT0 4'hE
`define SW_RSVD_LO 8'h40
`define SW_RSVD_HI 8'h5F
`define SW_TOS_LO 8'h60
`define SW_TOS_HI 8'h67
`define SW_MAC_LO 8'h68
`define SW_MAC_HI 8'h6D
`define SW_INDC_LO 8'h6E
`define SW_INDC_HI 8'h6F
`define SW_INDD_LO 8'h70
`define SW_INDD_HI 8'h78
`define SW_DTS_LO 8'h79
`define SW_DTS_HI 8'h7A
`define SW_DTC_LO 8'h7B
`define SW_DTC_HI 8'h7C
`define SW_ATC_LO 8'h7D
`define SW_ATC_HI 8'h7E
`define SW_ATS 8'h7F
`define SW_MAP_TOP 8'h7F
`define SW_RUN_BIT 0
`define SW_CHIP_CODE_MSB 7
`define SW_CHIP_CODE_LSB 4
`define SW_MII_LP_REG 5'h05
`define SW_LP_PAUSE_BIT 10
`define SW_LP_ABIL_LSB 5
`define SW_REG_RESET 8'h00
`define SW_MASK_ALL 8'hFF
`define SW_MASK_RUN 8'h01
`define SW_MASK_NONE 8'h00
`define SW_EE_FIRST 8'h02
`define SW_EE_LAST 8'h7F

`endif

// ==== rtl/sw_pkg.sv ====
// types shared by the switch register bank modules
package sw_pkg;
    typedef enum {RG_ID, RG_GLOBAL, RG_RSVD, RG_USER, RG_PCTL, RG_PSTAT, RG_TOS, RG_MAC,
                  RG_INDC, RG_INDD, RG_DTS, RG_DTC, RG_ATC, RG_ATS} sw_region_t;
    typedef enum {RS_STRAP, RS_LOAD, RS_HOLD, RS_RUN} sw_run_state_t;
    typedef enum {LD_IDLE, LD_ID0, LD_ID1, LD_COPY, LD_DONE} sw_ld_state_t;
endpackage

// ==== rtl/sw_ld_if.sv ====
// carrier between the register bank and the eeprom loader
interface sw_ld_if;
    logic start;
    logic done;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    modport regs (output start, input done, input wr_en, input wr_addr, input wr_data);
    modport loader (input start, output done, output wr_en, output wr_addr, output wr_data);
endinterface

// ==== rtl/sw_ee_loader.sv ====
// eeprom identity check and register override sequencer
`include "sw_regs.svh"
module sw_ee_loader
    import sw_pkg::*;
#(
    parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
    parameter logic [3:0] CHIP_CODE = 4'h3 // arbitrary value
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    sw_ld_if.loader ld,
    output logic ee_req_o,
    output logic [7:0] ee_addr_o,
    input wire logic ee_ack_i,
    input wire logic [7:0] ee_data_i,
    input wire logic ee_absent_i
);
    typedef struct packed {
        sw_ld_state_t state;
        logic id0_ok;
        logic req;
        logic [7:0] addr;
        logic done;
        logic wr_en;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } sw_ld_t;

    sw_ld_t s_r;
    sw_ld_t s_nxt;

    // one byte per ack; the request stands until the last byte, a failed identity or absence
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.wr_en = 1'b0;
        case (s_r.state)
            LD_IDLE:
            begin
                if (ld.start)
                begin
                    s_nxt.addr = `SW_OFF_FAMILY;
                    s_nxt.req = 1'b1;
                    s_nxt.state = LD_ID0;
                end
            end
            LD_ID0:
            begin
                if (ee_absent_i)
                begin
                    s_nxt.state = LD_DONE;
                end
                else if (ee_ack_i)
                begin
                    s_nxt.id0_ok = (ee_data_i == FAMILY_CODE);
                    s_nxt.addr = `SW_OFF_CHIP;
                    s_nxt.state = LD_ID1;
                end
            end
            LD_ID1:
            begin
                if (ee_absent_i)
                begin
                    s_nxt.state = LD_DONE;
                end
                else if (ee_ack_i)
                begin
                    // a failed identity leaves every default untouched
                    if (s_r.id0_ok && ee_data_i[`SW_CHIP_CODE_MSB:`SW_CHIP_CODE_LSB] == CHIP_CODE)
                    begin
                        s_nxt.addr = `SW_EE_FIRST;
                        s_nxt.state = LD_COPY;
                    end
                    else
                    begin
                        s_nxt.state = LD_DONE;
                    end
                end
            end
            LD_COPY:
            begin
                if (ee_absent_i)
                begin
                    s_nxt.state = LD_DONE;
                end
                else if (ee_ack_i)
                begin
                    s_nxt.wr_en = 1'b1;
                    s_nxt.wr_addr = s_r.addr;
                    s_nxt.wr_data = ee_data_i;
                    if (s_r.addr == `SW_EE_LAST)
                    begin
                        s_nxt.state = LD_DONE;
                    end
                    else
                    begin
                        s_nxt.addr = s_r.addr + 8'h01;
                    end
                end
            end
            LD_DONE:
            begin
                s_nxt.req = 1'b0;
                s_nxt.done = 1'b1;
            end
            default:
            begin
                s_nxt.state = LD_IDLE;
            end
        endcase
        // leaving the copy also drops the request in the same step
        if (s_nxt.state == LD_DONE)
        begin
            s_nxt.req = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_r <= '{state: LD_IDLE, default: '0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign ee_req_o = s_r.req;
    assign ee_addr_o = s_r.addr;
    assign ld.done = s_r.done;
    assign ld.wr_en = s_r.wr_en;
    assign ld.wr_addr = s_r.wr_addr;
    assign ld.wr_data = s_r.wr_data;
endmodule

// ==== rtl/sw_lp_ability.sv ====
// link partner ability capture and transceiver management read port
`include "sw_regs.svh"
module sw_lp_ability
#(
    parameter int NPHY = 2
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [NPHY-1:0] lp_pause_i,
    input wire logic [NPHY*4-1:0] lp_abil_i,
    input wire logic mii_rd_i,
    input wire logic [$clog2(NPHY)-1:0] mii_phy_i,
    input wire logic [4:0] mii_reg_i,
    output logic [15:0] mii_rdata_o,
    output logic [NPHY*5-1:0] lp_status_o
);
    typedef struct packed {
        logic [NPHY-1:0][4:0] lp;
        logic [15:0] rdata;
    } sw_lp_t;

    sw_lp_t s_r;
    sw_lp_t s_nxt;

    // abilities follow the partner inputs; management reads are registered
    always_comb
    begin
        s_nxt = s_r;
        for (int i = 0; i < NPHY; i++)
        begin
            s_nxt.lp[i] = {lp_pause_i[i], lp_abil_i[i*4 +: 4]};
        end
        if (mii_rd_i)
        begin
            s_nxt.rdata = 16'h0000;
            // next page, ack, remote fault and reserved bits stay zero; no write path exists
            if (mii_reg_i == `SW_MII_LP_REG && int'(mii_phy_i) < NPHY)
            begin
                s_nxt.rdata[`SW_LP_PAUSE_BIT] = s_r.lp[mii_phy_i][4];
                s_nxt.rdata[`SW_LP_ABIL_LSB +: 4] = s_r.lp[mii_phy_i][3:0];
            end
        end
    end

    // state register, all abilities clear at reset
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign mii_rdata_o = s_r.rdata;
    assign lp_status_o = s_r.lp;
endmodule

// ==== rtl/sw_top.sv ====
// switch register map, chip identity, start-switch control and start-up sequencing
`include "sw_regs.svh"
module sw_top
    import sw_pkg::*;
#(
    parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
    parameter logic [3:0] CHIP_CODE = 4'h3, // arbitrary value
    parameter logic [2:0] REVISION = 3'h1, // arbitrary value
    parameter int NPHY = 2
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic strap_select_high_i,
    input wire logic strap_select_low_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [NPHY-1:0] lp_pause_i,
    input wire logic [NPHY*4-1:0] lp_abil_i,
    input wire logic mii_rd_i,
    input wire logic [$clog2(NPHY)-1:0] mii_phy_i,
    input wire logic [4:0] mii_reg_i,
    output logic [15:0] mii_rdata_o,
    output logic ee_req_o,
    output logic [7:0] ee_addr_o,
    input wire logic ee_ack_i,
    input wire logic [7:0] ee_data_i,
    input wire logic ee_absent_i,
    output logic switch_run_o,
    output logic loading_o
);
    localparam int DEPTH = 128;

    typedef struct packed {
        sw_run_state_t state;
        logic auto_start;
        logic ld_start;
        logic run;
        logic [7:0] rdata;
        logic [DEPTH-1:0][7:0] mem;
    } sw_top_t;

    sw_top_t s_r;
    sw_top_t s_nxt;
    logic [NPHY*5-1:0] lp_status;
    sw_ld_if ld ();

    // region of an offset; everything at or above 0x80 counts as reserved
    function automatic sw_region_t sw_region_f(input logic [7:0] a);
        sw_region_t r;
        r = RG_RSVD;
        if (a <= `SW_OFF_CHIP)
        begin
            r = RG_ID;
        end
        else if (a <= `SW_GLOBAL_HI)
        begin
            r = RG_GLOBAL;
        end
        else if (a == `SW_RSVD_GLOBAL)
        begin
            r = RG_RSVD;
        end
        else if (a <= `SW_USER_HI)
        begin
            r = RG_USER;
        end
        else if (a <= `SW_PORT_HI)
        begin
            r = (a[3:0] <= `SW_PCTL_LAST) ? RG_PCTL : RG_PSTAT;
        end
        else if (a <= `SW_RSVD_HI)
        begin
            r = RG_RSVD;
        end
        else if (a <= `SW_TOS_HI)
        begin
            r = RG_TOS;
        end
        else if (a <= `SW_MAC_HI)
        begin
            r = RG_MAC;
        end
        else if (a <= `SW_INDC_HI)
        begin
            r = RG_INDC;
        end
        else if (a <= `SW_INDD_HI)
        begin
            r = RG_INDD;
        end
        else if (a <= `SW_DTS_HI)
        begin
            r = RG_DTS;
        end
        else if (a <= `SW_DTC_HI)
        begin
            r = RG_DTC;
        end
        else if (a <= `SW_ATC_HI)
        begin
            r = RG_ATC;
        end
        else if (a == `SW_ATS)
        begin
            r = RG_ATS;
        end
        return r;
    endfunction

    // writable bits of an offset, shared by host and eeprom writes
    function automatic logic [7:0] sw_wmask_f(input logic [7:0] a);
        logic [7:0] m;
        m = `SW_MASK_NONE;
        case (sw_region_f(a))
            RG_ID: m = (a == `SW_OFF_CHIP) ? `SW_MASK_RUN : `SW_MASK_NONE;
            RG_GLOBAL, RG_USER, RG_PCTL, RG_TOS, RG_MAC, RG_INDC, RG_INDD, RG_DTC, RG_ATC: m = `SW_MASK_ALL;
            default: m = `SW_MASK_NONE;
        endcase
        return m;
    endfunction

    // masked byte merge into the store
    function automatic logic [7:0] sw_merge_f(input logic [7:0] old, input logic [7:0] val, input logic [7:0] m);
        return (old & ~m) | (val & m);
    endfunction

    sw_ee_loader #(
        .FAMILY_CODE(FAMILY_CODE),
        .CHIP_CODE(CHIP_CODE)
    ) u_loader (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ld(ld.loader),
        .ee_req_o(ee_req_o),
        .ee_addr_o(ee_addr_o),
        .ee_ack_i(ee_ack_i),
        .ee_data_i(ee_data_i),
        .ee_absent_i(ee_absent_i)
    );

    sw_lp_ability #(
        .NPHY(NPHY)
    ) u_lp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lp_pause_i(lp_pause_i),
        .lp_abil_i(lp_abil_i),
        .mii_rd_i(mii_rd_i),
        .mii_phy_i(mii_phy_i),
        .mii_reg_i(mii_reg_i),
        .mii_rdata_o(mii_rdata_o),
        .lp_status_o(lp_status)
    );

    // start-up sequencing, register writes and registered read data
    always_comb
    begin
        logic [6:0] idx;
        logic [6:0] lidx;
        logic [1:0] port;
        idx = reg_addr_i[6:0];
        lidx = ld.wr_addr[6:0];
        port = reg_addr_i[5:4];
        s_nxt = s_r;
        s_nxt.ld_start = 1'b0;

        // host write first; an eeprom byte to the same offset wins in the same cycle
        if (reg_wr_i && reg_addr_i <= `SW_MAP_TOP)
        begin
            s_nxt.mem[idx] = sw_merge_f(s_r.mem[idx], reg_wdata_i, sw_wmask_f(reg_addr_i));
        end
        if (ld.wr_en && ld.wr_addr <= `SW_MAP_TOP)
        begin
            s_nxt.mem[lidx] = sw_merge_f(s_nxt.mem[lidx], ld.wr_data, sw_wmask_f(ld.wr_addr));
        end

        case (s_r.state)
            RS_STRAP:
            begin
                // straps sampled in the first clocked cycle after reset release
                s_nxt.auto_start = ~strap_select_high_i & ~strap_select_low_i;
                if (~strap_select_high_i & ~strap_select_low_i)
                begin
                    s_nxt.ld_start = 1'b1;
                    s_nxt.state = RS_LOAD;
                end
                else
                begin
                    s_nxt.state = RS_HOLD;
                end
            end
            RS_LOAD:
            begin
                // starts whether the eeprom was absent, rejected or copied
                if (ld.done)
                begin
                    s_nxt.state = RS_RUN;
                    s_nxt.run = 1'b1;
                end
            end
            RS_HOLD:
            begin
                if (s_r.mem[`SW_OFF_CHIP][`SW_RUN_BIT])
                begin
                    s_nxt.state = RS_RUN;
                    s_nxt.run = 1'b1;
                end
            end
            RS_RUN:
            begin
                // host-started switch stops again when the start bit is cleared
                if (!s_r.auto_start && !s_r.mem[`SW_OFF_CHIP][`SW_RUN_BIT])
                begin
                    s_nxt.state = RS_HOLD;
                    s_nxt.run = 1'b0;
                end
            end
            default:
            begin
                s_nxt.state = RS_STRAP;
                s_nxt.run = 1'b0;
            end
        endcase

        // read answer one cycle after the strobe, zero for reserved and unmapped
        if (reg_rd_i)
        begin
            s_nxt.rdata = `SW_REG_RESET;
            case (sw_region_f(reg_addr_i))
                RG_ID:
                begin
                    if (reg_addr_i == `SW_OFF_FAMILY)
                    begin
                        s_nxt.rdata = FAMILY_CODE;
                    end
                    else
                    begin
                        s_nxt.rdata = {CHIP_CODE, REVISION, s_r.mem[`SW_OFF_CHIP][`SW_RUN_BIT]};
                    end
                end
                RG_PSTAT:
                begin
                    // only the first status byte of a transceiver port carries partner abilities
                    if (reg_addr_i[3:0] == `SW_PSTAT0 && int'(port) >= 1 && int'(port) <= NPHY)
                    begin
                        s_nxt.rdata = {3'b000, lp_status[(int'(port) - 1) * 5 +: 5]};
                    end
                end
                RG_GLOBAL, RG_USER, RG_PCTL, RG_TOS, RG_MAC, RG_INDC, RG_INDD, RG_DTC, RG_ATC:
                begin
                    s_nxt.rdata = s_r.mem[idx];
                end
                default:
                begin
                    s_nxt.rdata = `SW_REG_RESET;
                end
            endcase
        end
    end

    // state register; built-in defaults are all zero
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_r <= '{state: RS_STRAP, default: '0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign ld.start = s_r.ld_start;
    assign reg_rdata_o = s_r.rdata;
    assign switch_run_o = s_r.run;
    assign loading_o = (s_r.state == RS_LOAD); // busy while the eeprom is tried
endmodule

// ==== tb/sw_top_monitor.sv ====
// concurrent checks on the switch register bank top ports
module sw_top_monitor
#(
    parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
    parameter logic [3:0] CHIP_CODE = 4'h3, // arbitrary value
    parameter logic [2:0] REVISION = 3'h1, // arbitrary value
    parameter int NPHY = 2
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic strap_select_high_i,
    input wire logic strap_select_low_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [NPHY-1:0] lp_pause_i,
    input wire logic [NPHY*4-1:0] lp_abil_i,
    input wire logic mii_rd_i,
    input wire logic [$clog2(NPHY)-1:0] mii_phy_i,
    input wire logic [4:0] mii_reg_i,
    input wire logic [15:0] mii_rdata_o,
    input wire logic ee_req_o,
    input wire logic [7:0] ee_addr_o,
    input wire logic ee_ack_i,
    input wire logic [7:0] ee_data_i,
    input wire logic ee_absent_i,
    input wire logic switch_run_o,
    input wire logic loading_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // identity bytes; the run bit is left out since the host owns it
    family_ro_a:
    assert property (reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == FAMILY_CODE) else $error("family code wrong");
    chip_code_a:
    assert property (reg_rd_i && reg_addr_i == 8'h01 |=> reg_rdata_o[7:1] == {CHIP_CODE, REVISION})
        else $error("chip code or revision wrong");
    // inputs must be stable, capture adds one cycle ahead of the read
    lp_mii_read_a:
    assert property (mii_rd_i && mii_reg_i == 5'h05 && mii_phy_i == '0 && !$past(rst_i) && $stable(lp_pause_i)
        && $stable(lp_abil_i) |=> mii_rdata_o == {5'h00, $past(lp_pause_i[0]), 1'b0, $past(lp_abil_i[3:0]), 5'h00})
        else $error("partner ability read wrong");
    lp_status_mirror_a:
    assert property (reg_rd_i && reg_addr_i == 8'h1E && !$past(rst_i) && $stable(lp_pause_i) && $stable(lp_abil_i)
        |=> reg_rdata_o == {3'b000, $past(lp_pause_i[0]), $past(lp_abil_i[3:0])}) else $error("port status wrong");
    start_bit_run_a:
    assert property ((strap_select_high_i || strap_select_low_i) && reg_wr_i && reg_addr_i == 8'h01
        |=> ##1 switch_run_o == $past(reg_wdata_i[0], 2)) else $error("run does not follow start bit");
    ee_addr_step_a:
    assert property (ee_req_o && ee_ack_i && ee_addr_o != 8'h01 && ee_addr_o != 8'h7F
        |=> ee_req_o && ee_addr_o == $past(ee_addr_o) + 8'h01) else $error("eeprom address did not step");
    id_fail_stop_a:
    assert property (ee_req_o && ee_ack_i && ee_addr_o == 8'h01 && ee_data_i[7:4] != CHIP_CODE |=> !ee_req_o)
        else $error("copy went on after identity mismatch");
    absent_start_a:
    assert property (ee_req_o && ee_absent_i |-> ##[1:4] switch_run_o) else $error("no start without eeprom");
    load_then_run_a:
    assert property ($fell(loading_o) |-> ##[0:3] switch_run_o) else $error("no start after load");
    no_run_loading_a:
    assert property (loading_o |-> !switch_run_o) else $error("running before eeprom attempt ended");
endmodule

// ==== tb/sw_ee_model.sv ====
// behavioural serial eeprom holding a register image
module sw_ee_model
#(
    parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
    parameter logic [3:0] CHIP_CODE = 4'h3 // arbitrary value
)
(
    input wire logic clk_i,
    input wire logic [1:0] mode_i,
    input wire logic [1:0] slow_i,
    input wire logic ee_req_i,
    input wire logic [7:0] ee_addr_i,
    output logic ee_ack_o,
    output logic [7:0] ee_data_o,
    output logic ee_absent_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] wait_r;
    initial
    begin
        ee_ack_o = 1'b0;
        ee_data_o = 8'h00;
        wait_r = 2'd0;
    end
    // mode 0 no part, 1 good identity, 2 wrong chip code
    assign ee_absent_o = ee_req_i && mode_i == 2'd0;
    // one ack per request, a gap after it so the new address is seen; data flips when idle
    always @(posedge clk_i)
    begin
        if (ee_ack_o)
        begin
            ee_ack_o <= 1'b0;
            ee_data_o <= ~ee_data_o;
            wait_r <= slow_i;
        end
        else if (ee_req_i && mode_i != 2'd0 && wait_r == 2'd0)
        begin
            ee_ack_o <= 1'b1;
            if (ee_addr_i == 8'h00)
                ee_data_o <= FAMILY_CODE;
            else if (ee_addr_i == 8'h01)
                ee_data_o <= {CHIP_CODE ^ ((mode_i == 2'd2) ? 4'hF : 4'h0), 4'h6};
            else
                ee_data_o <= ee_addr_i ^ 8'h5C;
        end
        else
        begin
            ee_data_o <= ~ee_data_o;
            if (wait_r != 2'd0)
                wait_r <= wait_r - 2'd1;
        end
    end
endmodule

// ==== tb/switch_id_start_and_map_tb.sv ====
// self-checking bench for the switch register map, identity and start-up
module switch_id_start_and_map_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] FAM = 8'h5A; // arbitrary value
    localparam logic [3:0] CHIP = 4'h3; // arbitrary value
    localparam logic [2:0] REV = 3'h5; // arbitrary value
    logic clk_i, rst_i, strap_hi, strap_lo, reg_wr_i, reg_rd_i, mii_rd_i, ee_req_o, ee_ack_i, ee_absent_i;
    logic switch_run_o, loading_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, ee_addr_o, ee_data_i, lp_abil_i;
    logic [1:0] lp_pause_i, ee_mode, ee_slow;
    logic [0:0] mii_phy_i;
    logic [4:0] mii_reg_i;
    logic [15:0] mii_rdata_o;
    logic [7:0] pick [6] = '{8'h02, 8'h0F, 8'h1D, 8'h60, 8'h78, 8'h7E};
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    sw_top #(.FAMILY_CODE(FAM), .CHIP_CODE(CHIP), .REVISION(REV)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .strap_select_high_i(strap_hi), .strap_select_low_i(strap_lo), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .lp_pause_i(lp_pause_i),
        .lp_abil_i(lp_abil_i), .mii_rd_i(mii_rd_i), .mii_phy_i(mii_phy_i), .mii_reg_i(mii_reg_i),
        .mii_rdata_o(mii_rdata_o), .ee_req_o(ee_req_o), .ee_addr_o(ee_addr_o), .ee_ack_i(ee_ack_i),
        .ee_data_i(ee_data_i), .ee_absent_i(ee_absent_i), .switch_run_o(switch_run_o), .loading_o(loading_o));
    sw_ee_model #(.FAMILY_CODE(FAM), .CHIP_CODE(CHIP)) u_ee (.clk_i(clk_i), .mode_i(ee_mode), .slow_i(ee_slow),
        .ee_req_i(ee_req_o), .ee_addr_i(ee_addr_o), .ee_ack_o(ee_ack_i), .ee_data_o(ee_data_i),
        .ee_absent_o(ee_absent_i));
    // free-running system clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // read strobe for one cycle, data settles on the taking edge
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(what, {8'h00, reg_rdata_o}, {8'h00, exp});
    endtask
    task automatic mrc(input logic p, input logic [4:0] r, input logic [15:0] exp, input string what);
        @(posedge clk_i);
        mii_rd_i <= 1'b1;
        mii_phy_i <= p;
        mii_reg_i <= r;
        @(posedge clk_i);
        mii_rd_i <= 1'b0;
        #1 chk(what, mii_rdata_o, exp);
    endtask
    // straps change only inside reset
    task automatic start(input logic hi, input logic lo, input logic [1:0] m, input logic [1:0] s);
        @(posedge clk_i);
        rst_i <= 1'b1;
        strap_hi <= hi;
        strap_lo <= lo;
        ee_mode <= m;
        ee_slow <= s;
        @(posedge clk_i);
        #1 chk("mii in reset", mii_rdata_o, 16'h0000);
        @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic wait_run();
        for (int i = 0; i < 600 && switch_run_o !== 1'b1; i++)
            @(negedge clk_i);
        chk("auto run", switch_run_o, 16'h0001);
        chk("loading end", loading_o, 16'h0000);
    endtask
    function automatic logic wr_ok(input logic [7:0] a);
        return (a >= 8'h02 && a <= 8'h0B) || (a >= 8'h0D && a <= 8'h0F) || (a >= 8'h10 && a <= 8'h3F && a[3:0] <= 4'hD)
            || (a >= 8'h60 && a <= 8'h78) || (a >= 8'h7B && a <= 8'h7E);
    endfunction
    // hang guard, well above the expected run length
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        rst_i = 1'b1;
        strap_hi = 1'b1;
        strap_lo = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        lp_pause_i = 2'b00;
        lp_abil_i = 8'h00;
        mii_rd_i = 1'b0;
        mii_phy_i = 1'b0;
        mii_reg_i = 5'h00;
        ee_mode = 2'd0;
        ee_slow = 2'd0;
        // host-started mode: identity and start bit
        start(1'b1, 1'b0, 2'd0, 2'd0);
        rdc(8'h00, FAM, "family");
        rdc(8'h01, {CHIP, REV, 1'b0}, "chip id");
        chk("stopped", switch_run_o, 16'h0000);
        wr(8'h00, 8'hFF);
        wr(8'h01, 8'hFF);
        rdc(8'h00, FAM, "family ro");
        rdc(8'h01, {CHIP, REV, 1'b1}, "start bit");
        chk("running", switch_run_o, 16'h0001);
        wr(8'h01, 8'h00);
        @(posedge clk_i);
        #1 chk("stopped again", switch_run_o, 16'h0000);
        $display("test start control done");
        // full map: write everything first so aliased decodes show up on read
        for (int a = 2; a < 128; a++)
            wr(a[7:0], a[7:0] ^ 8'hA5);
        for (int a = 2; a < 256; a++)
            rdc(a[7:0], wr_ok(a[7:0]) ? a[7:0] ^ 8'hA5 : 8'h00, "map");
        $display("test register map done");
        // partner adverts, swapped between ports on the second pass
        for (int k = 0; k < 2; k++)
        begin
            lp_pause_i <= (k == 0) ? 2'b01 : 2'b10;
            lp_abil_i <= (k == 0) ? 8'hA5 : 8'h5A;
            repeat (3) @(posedge clk_i);
            mrc(1'b0, 5'h05, (k == 0) ? 16'h04A0 : 16'h0140, "lp port1");
            mrc(1'b1, 5'h05, (k == 0) ? 16'h0140 : 16'h04A0, "lp port2");
            rdc(8'h1E, (k == 0) ? 8'h15 : 8'h0A, "status port1");
            rdc(8'h2E, (k == 0) ? 8'h0A : 8'h15, "status port2");
        end
        mrc(1'b0, 5'h04, 16'h0000, "other mii reg");
        $display("test partner ability done");
        // automatic start with a good image, prompt answers
        start(1'b0, 1'b0, 2'd1, 2'd0);
        wait_run();
        for (int i = 0; i < 6; i++)
            rdc(pick[i], pick[i] ^ 8'h5C, "image copy");
        rdc(8'h01, {CHIP, REV, 1'b0}, "id kept");
        rdc(8'h1E, 8'h0A, "status kept");
        $display("test good eeprom done");
        // wrong chip code with slow answers, then no part at all
        for (int m = 2; m >= 0; m -= 2)
        begin
            start(1'b0, 1'b0, m[1:0], 2'd2);
            wait_run();
            for (int i = 0; i < 6; i++)
                rdc(pick[i], 8'h00, "defaults kept");
            $display("test eeprom mode %0d done", m);
        end
        print_verdict();
    end
endmodule
bind sw_top sw_top_monitor #(.FAMILY_CODE(FAMILY_CODE), .CHIP_CODE(CHIP_CODE), .REVISION(REVISION), .NPHY(NPHY))
    u_mon (.clk_i(clk_i), .rst_i(rst_i), .strap_select_high_i(strap_select_high_i),
    .strap_select_low_i(strap_select_low_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .lp_pause_i(lp_pause_i), .lp_abil_i(lp_abil_i),
    .mii_rd_i(mii_rd_i), .mii_phy_i(mii_phy_i), .mii_reg_i(mii_reg_i), .mii_rdata_o(mii_rdata_o),
    .ee_req_o(ee_req_o), .ee_addr_o(ee_addr_o), .ee_ack_i(ee_ack_i), .ee_data_i(ee_data_i),
    .ee_absent_i(ee_absent_i), .switch_run_o(switch_run_o), .loading_o(loading_o));
